//--- rtl/uhomc_pkg.sv
`default_nettype none
package uhomc_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int BE_W = DW / 8;
    localparam int CNT_W = 20;
    // Timing: the clock period and the documented times in nanoseconds.
    localparam int CLK_NS = 10;
    localparam int FRAME_NS = 1000000;
    localparam int IGNORE_NS = 3000000;
    localparam int FRAME_CYC = FRAME_NS / CLK_NS;
    localparam int IGNORE_CYC = IGNORE_NS / CLK_NS;
    // Register byte offsets.
    localparam logic [AW-1:0] OFS_VERSION = 8'h00;
    localparam logic [AW-1:0] OFS_MODE = 8'h04;
    localparam logic [AW-1:0] OFS_CTL_HEAD = 8'h20;
    localparam logic [AW-1:0] OFS_CTL_NOW = 8'h24;
    localparam logic [AW-1:0] OFS_BULK_HEAD = 8'h28;
    localparam logic [AW-1:0] OFS_BULK_NOW = 8'h2c;
    localparam logic [AW-1:0] OFS_CMD = 8'h60;
    localparam logic [AW-1:0] OFS_STAT = 8'h64;
    localparam int NPTR = 4;
    localparam logic [AW-1:0] PTR_OFS [NPTR] = '{8'h20, 8'h24, 8'h28, 8'h2c};
    // Field positions of the operating mode register.
    localparam int BIT_RWE = 10;
    localparam int BIT_RWC = 9;
    localparam int BIT_IR = 8;
    localparam int FS_LO = 6;
    localparam int BIT_BLE = 5;
    localparam int BIT_CLE = 4;
    localparam int VER_W = 8;
    // Command and status register fields.
    localparam int BIT_SOFT_RST = 0;
    localparam int STAT_SOF = 0;
    localparam int STAT_IGN = 1;
    localparam int STAT_CTL = 2;
    localparam int STAT_BULK = 3;
    localparam int STAT_RHRST = 4;
    localparam logic RWC_RST = 1'b0;
    localparam logic [DW-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0] FS_CODE_RESET = 2'h0;
    localparam logic [1:0] FS_CODE_RESUME = 2'h1;
    localparam logic [1:0] FS_CODE_OPER = 2'h2;
    localparam logic [1:0] FS_CODE_SUSP = 2'h3;

    typedef enum logic [3:0] {
        FS_RESET = 4'h1,
        FS_RESUME = 4'h2,
        FS_OPER = 4'h4,
        FS_SUSP = 4'h8
    } uhomc_fs_t;

    function automatic logic [1:0] fsCode(input uhomc_fs_t s);
        case (s)
            FS_RESUME: fsCode = FS_CODE_RESUME;
            FS_OPER: fsCode = FS_CODE_OPER;
            FS_SUSP: fsCode = FS_CODE_SUSP;
            default: fsCode = FS_CODE_RESET;
        endcase
    endfunction

    function automatic uhomc_fs_t fsState(input logic [1:0] c);
        case (c)
            FS_CODE_RESUME: fsState = FS_RESUME;
            FS_CODE_OPER: fsState = FS_OPER;
            FS_CODE_SUSP: fsState = FS_SUSP;
            default: fsState = FS_RESET;
        endcase
    endfunction

    function automatic logic [DW-1:0] byteMerge(input logic [DW-1:0] old,
                                                input logic [DW-1:0] wd,
                                                input logic [BE_W-1:0] be);
        byteMerge = old;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                byteMerge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction
endpackage
`default_nettype wire

//--- rtl/uhomc_frm_if.sv
`timescale 1ns/1ns
`default_nettype none
interface uhomc_frm_if;
    logic runFrames;
    logic loadIgnore;
    logic frameTick;
    logic ignoreBusy;
    modport timer (input runFrames, input loadIgnore, output frameTick, output ignoreBusy);
    modport ctl (output runFrames, output loadIgnore, input frameTick, input ignoreBusy);
endinterface
`default_nettype wire

//--- rtl/uhomc_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module uhomc_sync2 (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule
`default_nettype wire

//--- rtl/uhomc_frame_timer.sv
`timescale 1ns/1ns
`default_nettype none
module uhomc_frame_timer
    import uhomc_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = uhomc_pkg::FRAME_CYC,
    parameter int unsigned IGNORE_CYCLES = uhomc_pkg::IGNORE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    uhomc_frm_if.timer frm
);
    localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_CYCLES - 1);
    localparam logic [CNT_W-1:0] IGN_LOAD = CNT_W'(IGNORE_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

    logic [CNT_W-1:0] frameCnt_q;
    logic [CNT_W-1:0] ignCnt_q;

    // The frame counter restarts whenever frames stop, so the first tick
    // comes one whole frame after running begins.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frameCnt_q <= CNT_ZERO;
        end else if (!frm.runFrames || frm.frameTick) begin
            frameCnt_q <= CNT_ZERO;
        end else begin
            frameCnt_q <= frameCnt_q + CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ignCnt_q <= CNT_ZERO;
        end else if (frm.loadIgnore) begin
            ignCnt_q <= IGN_LOAD;
        end else if (frm.ignoreBusy) begin
            ignCnt_q <= ignCnt_q - CNT_ONE;
        end
    end

    assign frm.frameTick = frm.runFrames && (frameCnt_q == FRAME_LAST);
    assign frm.ignoreBusy = (ignCnt_q != CNT_ZERO);
endmodule
`default_nettype wire

//--- rtl/uhomc_top.sv
`timescale 1ns/1ns
`default_nettype none
module uhomc_top #(
    parameter int unsigned FRAME_CYCLES = uhomc_pkg::FRAME_CYC,
    parameter int unsigned IGNORE_CYCLES = uhomc_pkg::IGNORE_CYC,
    // Revision value is arbitrary.
    parameter logic [uhomc_pkg::VER_W-1:0] VERSION_NUM = 8'h5a
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [uhomc_pkg::AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [uhomc_pkg::DW-1:0] avs_writedata,
    input wire logic [uhomc_pkg::BE_W-1:0] avs_byteenable,
    output logic [uhomc_pkg::DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic resumeDetect,
    input wire logic irqIn,
    output logic sofPulse,
    output logic rootHubRst,
    output logic usbResetDrive,
    output logic ctlListRun,
    output logic bulkListRun,
    output logic ignoreUpstream,
    output logic l2Irq
);
    import uhomc_pkg::*;

    localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
    localparam logic [CNT_W-1:0] CNT_MAX = 20'hfffff;
    localparam logic [CNT_W-1:0] FRAME_MARK = CNT_W'(FRAME_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic waitReq_q;
    logic [DW-1:0] readData_q;
    uhomc_fs_t fs_q;
    uhomc_fs_t fsD;
    logic rwe_q;
    logic rwc_q;
    logic ir_q;
    logic ble_q;
    logic cle_q;
    logic [DW-1:0] listPtr_q [NPTR];
    logic sofPulse_q;
    logic sofOn_q;
    logic rootRst_q;
    logic usbRstDrv_q;
    logic ctlRun_q;
    logic bulkRun_q;
    logic ignoreUp_q;
    logic l2Irq_q;
    logic resumeSync;
    logic [NPTR-1:0] hitPtr;
    logic [DW-1:0] ptrRd [NPTR];
    logic [DW-1:0] ptrOr;

    uhomc_frm_if frm ();

    ////////////////////////////////////////////////////////////////////////
    // Helper blocks.

    uhomc_sync2 u_resumeSync (
        .sys_clk(sys_clk),
        .rst(rst),
        .asyncIn(resumeDetect),
        .syncOut(resumeSync)
    );

    uhomc_frame_timer #(
        .FRAME_CYCLES(FRAME_CYCLES),
        .IGNORE_CYCLES(IGNORE_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .frm(frm.timer)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and read selection.

    wire isReq = avs_read || avs_write;
    wire wrFire = avs_write && !waitReq_q;
    wire rdLatch = avs_read && waitReq_q;
    wire hitVer = (avs_address == OFS_VERSION);
    wire hitMode = (avs_address == OFS_MODE);
    wire hitCmd = (avs_address == OFS_CMD);
    wire hitStat = (avs_address == OFS_STAT);
    wire isOper = (fs_q == FS_OPER);

    genvar gi;
    generate
        for (gi = 0; gi < NPTR; gi++) begin : g_ptr
            assign hitPtr[gi] = (avs_address == PTR_OFS[gi]);
            assign ptrRd[gi] = hitPtr[gi] ? listPtr_q[gi] : ZERO_WORD;
        end
    endgenerate

    always_comb begin
        ptrOr = ZERO_WORD;
        for (int i = 0; i < NPTR; i++) begin
            ptrOr = ptrOr | ptrRd[i];
        end
    end

    logic [DW-1:0] modeWord;
    logic [DW-1:0] statWord;
    always_comb begin
        modeWord = ZERO_WORD;
        modeWord[BIT_RWE] = rwe_q;
        modeWord[BIT_RWC] = rwc_q;
        modeWord[BIT_IR] = ir_q;
        modeWord[FS_LO +: 2] = fsCode(fs_q);
        modeWord[BIT_BLE] = ble_q;
        modeWord[BIT_CLE] = cle_q;
        statWord = ZERO_WORD;
        statWord[STAT_SOF] = sofOn_q;
        statWord[STAT_IGN] = ignoreUp_q;
        statWord[STAT_CTL] = ctlRun_q;
        statWord[STAT_BULK] = bulkRun_q;
        statWord[STAT_RHRST] = rootRst_q;
    end

    wire [DW-1:0] verWord = {{(DW - VER_W){1'b0}}, VERSION_NUM};
    wire [DW-1:0] rdMux = hitVer ? verWord :
                          hitMode ? modeWord :
                          hitStat ? statWord :
                          ptrOr;
    wire [DW-1:0] newMode = byteMerge(modeWord, avs_writedata, avs_byteenable);
    wire [1:0] wrCode = newMode[FS_LO +: 2];
    wire wrMode = wrFire && hitMode;
    wire softRst = wrFire && hitCmd && avs_byteenable[BIT_SOFT_RST / 8] &&
                   avs_writedata[BIT_SOFT_RST];

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, read data latched before it ends.

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            waitReq_q <= 1'b1;
        end else begin
            waitReq_q <= !(isReq && waitReq_q);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            readData_q <= ZERO_WORD;
        end else if (rdLatch) begin
            readData_q <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Functional state. Software reset beats a wake, a wake beats a write.

    wire resumeSeen = (fs_q == FS_SUSP) && resumeSync && rwe_q;
    assign fsD = softRst ? FS_SUSP :
                 resumeSeen ? FS_RESUME :
                 wrMode ? fsState(newMode[FS_LO +: 2]) :
                 fs_q;
    wire enterOper = (fsD == FS_OPER) && !isOper;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fs_q <= FS_RESET;
        end else begin
            fs_q <= fsD;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rwe_q <= 1'b0;
            rwc_q <= RWC_RST;
            ir_q <= 1'b0;
            ble_q <= 1'b0;
            cle_q <= 1'b0;
        end else if (softRst) begin
            rwe_q <= 1'b0;
            ir_q <= 1'b0;
            ble_q <= 1'b0;
            cle_q <= 1'b0;
        end else if (wrMode) begin
            rwe_q <= newMode[BIT_RWE];
            rwc_q <= newMode[BIT_RWC];
            ir_q <= newMode[BIT_IR];
            ble_q <= newMode[BIT_BLE];
            cle_q <= newMode[BIT_CLE];
        end
    end

    // List pointers are used as loaded; software keeps them valid.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NPTR; i++) begin
                listPtr_q[i] <= ZERO_WORD;
            end
        end else begin
            for (int i = 0; i < NPTR; i++) begin
                if (wrFire && hitPtr[i]) begin
                    listPtr_q[i] <= byteMerge(listPtr_q[i], avs_writedata,
                                              avs_byteenable);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame timing and list processing.

    assign frm.runFrames = isOper;
    assign frm.loadIgnore = enterOper && (fs_q == FS_RESUME);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sofPulse_q <= 1'b0;
            sofOn_q <= 1'b0;
            ctlRun_q <= 1'b0;
            bulkRun_q <= 1'b0;
        end else begin
            sofPulse_q <= frm.frameTick && isOper;
            sofOn_q <= isOper && (sofOn_q || frm.frameTick);
            ctlRun_q <= isOper && (frm.frameTick ? cle_q : ctlRun_q);
            bulkRun_q <= isOper && (frm.frameTick ? ble_q : bulkRun_q);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rootRst_q <= 1'b1;
            usbRstDrv_q <= 1'b1;
            ignoreUp_q <= 1'b0;
            l2Irq_q <= 1'b0;
        end else begin
            rootRst_q <= (fs_q == FS_RESET);
            usbRstDrv_q <= (fs_q == FS_RESET);
            ignoreUp_q <= frm.ignoreBusy;
            l2Irq_q <= irqIn && !ir_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign avs_readdata = readData_q;
    assign avs_waitrequest = waitReq_q;
    assign sofPulse = sofPulse_q;
    assign rootHubRst = rootRst_q;
    assign usbResetDrive = usbRstDrv_q;
    assign ctlListRun = ctlRun_q;
    assign bulkListRun = bulkRun_q;
    assign ignoreUpstream = ignoreUp_q;
    assign l2Irq = l2Irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [CNT_W-1:0] operCnt_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            operCnt_q <= CNT_ZERO;
        end else if (!isOper) begin
            operCnt_q <= CNT_ZERO;
        end else if (operCnt_q != CNT_MAX) begin
            operCnt_q <= operCnt_q + CNT_ONE;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence seqResumeToOper;
        (fs_q == FS_RESUME) ##1 (fs_q == FS_OPER);
    endsequence

    sequence seqWakeInSuspend;
        (fs_q == FS_SUSP) && resumeSync && rwe_q && !softRst;
    endsequence

    chk_fs_encoding: assert property (
        (wrMode && !softRst && !resumeSeen) |=>
        ((fs_q == FS_OPER) == ($past(wrCode) == FS_CODE_OPER)) &&
        ((fs_q == FS_SUSP) == ($past(wrCode) == FS_CODE_SUSP)) &&
        ((fs_q == FS_RESET) == ($past(wrCode) == FS_CODE_RESET)))
        else $error("state field code does not match state");

    chk_sof_not_early: assert property (
        sofPulse_q |-> (operCnt_q >= FRAME_MARK))
        else $error("start of frame before one frame in operational");

    chk_sof_on_time: assert property (
        (operCnt_q == FRAME_MARK) |-> sofPulse_q)
        else $error("start of frame missing one frame after operational");

    chk_auto_resume: assert property (
        seqWakeInSuspend |=> (fs_q == FS_RESUME))
        else $error("downstream wake did not move suspend to resume");

    chk_soft_reset: assert property (
        softRst |=> (fs_q == FS_SUSP) && !ble_q && !cle_q)
        else $error("software reset did not enter suspend");

    chk_hw_reset: assert property (
        $past(rst) |-> (fs_q == FS_RESET) && rootRst_q)
        else $error("hardware reset did not enter reset state");

    chk_root_reset: assert property (
        (fs_q == FS_RESET) [*2] |-> rootRst_q && usbRstDrv_q)
        else $error("reset state not driving root hub reset");

    chk_irq_route: assert property (
        (irqIn && !ir_q) |=> l2Irq_q)
        else $error("interrupt not passed to processor");

    chk_irq_blocked: assert property (
        !(irqIn && !ir_q) |=> !l2Irq_q)
        else $error("interrupt passed while idle or routed away");

    chk_bulk_off: assert property (
        (frm.frameTick && !ble_q) |=> !bulkRun_q)
        else $error("bulk list still processed after disable");

    chk_bulk_on: assert property (
        (frm.frameTick && ble_q && isOper && fsD == FS_OPER) |=> bulkRun_q)
        else $error("bulk list not processed while enabled");

    chk_ctl_off: assert property (
        (frm.frameTick && !cle_q) |=> !ctlRun_q)
        else $error("control list still processed after disable");

    chk_ctl_on: assert property (
        (frm.frameTick && cle_q && isOper && fsD == FS_OPER) |=> ctlRun_q)
        else $error("control list not processed while enabled");

    chk_ignore_window: assert property (
        seqResumeToOper |=> ignoreUp_q [*8])
        else $error("upstream traffic not ignored after resume");
endmodule
`default_nettype wire

//--- verif/uhomc_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module uhomc_dev_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wakeReq,
    input wire logic usbResetDrive,
    output logic resumeDetect
);
    // A device held in bus reset cannot signal a wake-up.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resumeDetect <= 1'b0;
        end else begin
            resumeDetect <= wakeReq & ~usbResetDrive;
        end
    end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import uhomc_pkg::*;
    localparam int unsigned FRM = 20;
    localparam int unsigned IGN = 40;
    localparam int LIMIT = 20000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [AW-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DW-1:0] avs_writedata = '0;
    logic [BE_W-1:0] avs_byteenable = '0;
    logic [DW-1:0] avs_readdata;
    logic avs_waitrequest;
    logic resumeDetect;
    logic irqIn = 1'b0;
    logic wakeReq = 1'b0;
    logic sofPulse, rootHubRst, usbResetDrive, ctlListRun, bulkListRun, ignoreUpstream, l2Irq;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed = 94;
    logic [DW-1:0] d, v, pv;
    logic e;
    int k, n;

    always #5 sys_clk = ~sys_clk;

    uhomc_top #(.FRAME_CYCLES(FRM), .IGNORE_CYCLES(IGN)) uhomc_top_inst (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .resumeDetect(resumeDetect), .irqIn(irqIn), .sofPulse(sofPulse),
        .rootHubRst(rootHubRst), .usbResetDrive(usbResetDrive), .ctlListRun(ctlListRun),
        .bulkListRun(bulkListRun), .ignoreUpstream(ignoreUpstream), .l2Irq(l2Irq));

    uhomc_dev_model uhomc_dev_model_inst (.sys_clk(sys_clk), .rst(rst), .wakeReq(wakeReq),
        .usbResetDrive(usbResetDrive), .resumeDetect(resumeDetect));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [DW-1:0] modeWord(input logic rwa, input logic rww,
            input logic ir, input logic [1:0] fs, input logic bulk_list_on, input logic cle);
        modeWord = ZERO_WORD;
        modeWord[BIT_RWE] = rwa;
        modeWord[BIT_RWC] = rww;
        modeWord[BIT_IR] = ir;
        modeWord[FS_LO +: 2] = fs;
        modeWord[BIT_BLE] = bulk_list_on;
        modeWord[BIT_CLE] = cle;
    endfunction

    task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // The request is held until waitrequest is sampled low, then released.
    task automatic access(input logic wrNotRd, input logic [AW-1:0] a,
            input logic [DW-1:0] wd, input logic [BE_W-1:0] be, output logic [DW-1:0] rd);
        int w;
        w = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_write <= wrNotRd;
        avs_read <= ~wrNotRd;
        do begin
            @(posedge sys_clk);
            w++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        check(w, 32'h2, "bus answer");
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] wd);
        logic [DW-1:0] x;
        access(1'b1, a, wd, 4'hf, x);
    endtask

    task automatic rdChk(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string what);
        logic [DW-1:0] x;
        access(1'b0, a, ZERO_WORD, 4'h0, x);
        check(x, exp, what);
    endtask

    task automatic waitSof(output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
        end while (sofPulse !== 1'b1 && cnt < 3 * FRM);
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check({31'h0, rootHubRst & usbResetDrive}, 32'h1, "hub reset after reset");
        rdChk(OFS_MODE, modeWord(0, RWC_RST, 0, FS_CODE_RESET, 0, 0), "mode reset");
        rdChk(OFS_VERSION, {24'h0, 8'h5a}, "version");
        wr(OFS_VERSION, 32'hffff_ffff);
        rdChk(OFS_VERSION, {24'h0, 8'h5a}, "version read only");
        wr(8'h10, 32'hffff_ffff);
        rdChk(8'h10, ZERO_WORD, "unmapped");
        for (int i = 0; i < NPTR; i++) begin
            rdChk(PTR_OFS[i], ZERO_WORD, "pointer reset");
            v = $random(seed);
            v[3:0] = 4'h0;
            wr(PTR_OFS[i], v);
            rdChk(PTR_OFS[i], v, "pointer");
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            d = modeWord(0, 0, 0, 2'(3 - i), 0, 0);
            if (i == 3) begin
                d = modeWord(0, 0, 0, FS_CODE_RESET, 0, 0);
            end
            wr(OFS_MODE, d);
            rdChk(OFS_MODE, d, "state code");
            repeat (2) @(posedge sys_clk);
            check({31'h0, rootHubRst}, {31'h0, d[FS_LO +: 2] == 2'h0}, "hub reset");
            check({31'h0, usbResetDrive}, {31'h0, d[FS_LO +: 2] == 2'h0}, "bus reset");
        end
        $display("test states done");
        wr(OFS_MODE, modeWord(0, 0, 0, FS_CODE_SUSP, 0, 0));
        wr(OFS_MODE, modeWord(0, 0, 0, FS_CODE_OPER, 0, 0));
        waitSof(k);
        check(k, FRM + 1, "first frame start");
        waitSof(k);
        check(k, FRM, "frame spacing");
        wr(OFS_MODE, modeWord(0, 0, 0, FS_CODE_OPER, 1, 1));
        check({30'h0, ctlListRun, bulkListRun}, 32'h0, "lists wait for frame");
        waitSof(k);
        check({30'h0, ctlListRun, bulkListRun}, 32'h3, "lists on");
        rdChk(OFS_STAT, 32'h0000_000d, "status running");
        wr(OFS_MODE, modeWord(0, 0, 0, FS_CODE_OPER, 0, 1));
        check({31'h0, bulkListRun}, 32'h1, "bulk until frame end");
        waitSof(k);
        check({30'h0, ctlListRun, bulkListRun}, 32'h2, "bulk off");
        wr(OFS_MODE, modeWord(0, 0, 0, FS_CODE_OPER, 0, 0));
        waitSof(k);
        check({31'h0, ctlListRun}, 32'h0, "control off");
        pv = $random(seed);
        wr(OFS_BULK_NOW, pv);
        wr(OFS_CTL_NOW, pv);
        wr(OFS_MODE, modeWord(0, 0, 0, FS_CODE_OPER, 1, 1));
        waitSof(k);
        check({30'h0, ctlListRun, bulkListRun}, 32'h3, "lists back on");
        $display("test frames done");
        for (int ir = 0; ir < 2; ir++) begin
            wr(OFS_MODE, modeWord(0, 0, 1'(ir), FS_CODE_OPER, 1, 1));
            e = 1'b0;
            for (int j = 0; j < 12; j++) begin
                @(posedge sys_clk);
                check({31'h0, l2Irq}, {31'h0, e}, "processor interrupt");
                e = irqIn & ~1'(ir);
                irqIn <= 1'($random(seed));
            end
            irqIn <= 1'b0;
        end
        $display("test interrupt done");
        wr(OFS_MODE, modeWord(1, 1, 0, FS_CODE_OPER, 1, 1));
        wr(OFS_CMD, 32'h0000_0001);
        rdChk(OFS_MODE, modeWord(0, 1, 0, FS_CODE_SUSP, 0, 0), "software reset");
        rdChk(OFS_BULK_NOW, pv, "pointer kept");
        $display("test software reset done");
        wr(OFS_MODE, modeWord(1, 1, 0, FS_CODE_SUSP, 0, 0));
        wakeReq <= 1'b1;
        n = 0;
        do begin
            access(1'b0, OFS_MODE, ZERO_WORD, 4'h0, d);
            n++;
        end while (d[FS_LO +: 2] !== FS_CODE_RESUME && n < 20);
        check({30'h0, d[FS_LO +: 2]}, {30'h0, FS_CODE_RESUME}, "wake to resume");
        wakeReq <= 1'b0;
        wr(OFS_MODE, modeWord(1, 1, 0, FS_CODE_OPER, 0, 0));
        n = 0;
        repeat (IGN + 20) begin
            @(posedge sys_clk);
            n += int'(ignoreUpstream === 1'b1);
        end
        check(n, IGN, "ignore window length");
        $display("test wake done");
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check({31'h0, rootHubRst}, 32'h1, "hub held in reset");
        rst <= 1'b0;
        rdChk(OFS_MODE, modeWord(0, RWC_RST, 0, FS_CODE_RESET, 0, 0), "second reset");
        $display("test second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
